// >>> src/cep_core_exc.sv
// Exception controller, memory region guard and tick timer for a core.
// Assumes one AHB-Lite master on clk; irq lines are asynchronous pins;
// core-side strobes (sleep, return, memory access) are on clk.
//
// Behaviour
// - The guard holds eight regions, each with eight sub-regions that can be disabled singly.
// - An access hitting no region, or one the region forbids, is blocked and faults.
// - A region allows reads and writes, allows reads only, or denies all access; writes to a read-only region are blocked.
// - The tick timer steps on the system clock or on a divided copy of it.
// - Tick timer expiry raises its own exception apart from peripheral lines.
// - Eight priority levels per interrupt; requests at or below a nonzero mask level are held off.
// - The vector table base comes from a writable vector base offset register.
// - Any one interrupt source can be routed to the non-maskable exception.
// - System exceptions and peripheral interrupts are arbitrated in one ranking.
// - A more urgent request during entry replaces the pending one without a new entry.
// - Context is saved by hardware on entry and restored on return.
// - An enabled pending request while the core sleeps raises wake-up.
`timescale 1ns/10ps
`include "cep_defs.svh"
module cep_core_exc #(
  parameter int NIRQ = 56,
  parameter int NRGN = 8,
  parameter int TDIV = 8
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic      [31:0]     hrdata,
  input  wire logic [NIRQ-1:0] irq_line,
  input  wire logic            core_sleep,
  input  wire logic            exc_return,
  input  wire logic            mem_valid,
  input  wire logic [31:0]     mem_addr,
  input  wire logic            mem_write,
  output logic                 exc_req,
  output logic      [7:0]      exc_num,
  output logic      [31:0]     exc_vec,
  output logic                 ctx_save,
  output logic                 ctx_restore,
  output logic                 mem_block,
  output logic                 wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rgn_hit(input logic [31:0] base, input logic [31:0] attr,
                                   input logic [31:0] a);
    logic [4:0]  sz;
    logic [31:0] off;
    logic [2:0]  sub;
    sz = attr[`CEP_ATTR_SIZE_LSB +: 5];
    if (sz < `CEP_SIZE_MIN)
      sz = `CEP_SIZE_MIN;
    off = a - base;
    sub = off[sz - 5'h03 +: 3];
    return attr[`CEP_ATTR_EN] && (off >> sz) == 32'h0
           && !attr[`CEP_ATTR_SRD_LSB + sub];
  endfunction

  function automatic logic [31:0] vec_of(input logic [31:0] vb, input logic [7:0] n);
    return {vb[31:`CEP_VBASE_LSB], 7'h00} + {22'h0, n, 2'b00};
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        wr_q_r;
  logic [11:0] wa_q_r;
  logic [31:0] rd_c;
  logic [31:0] hrdata_r;
  logic        hready_r;
  logic        hresp_r;
  logic        take_c;

  assign take_c = hsel && htrans[1] && hready;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wr_q_r   <= 1'b0;
      wa_q_r   <= 12'h000;
      hrdata_r <= 32'h0;
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
    else
    begin
      wr_q_r   <= take_c && hwrite;
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
      if (take_c)
        wa_q_r <= haddr[11:0];
      if (take_c && !hwrite)
        hrdata_r <= rd_c;
    end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [23:0] reload_r;
  logic [31:0] vbase_r;
  logic [2:0]  mask_r;
  logic [8:0]  nmisel_r;
  logic [5:0]  sel_r;
  logic [31:0] rgn_base_r [NRGN];
  logic [31:0] rgn_attr_r [NRGN];
  logic [NIRQ-1:0] en_r;
  logic [2:0]  prio_r [NIRQ];
  logic        pset_c;
  logic [23:0] tick_val;

  assign pset_c = wr_q_r && wa_q_r == `CEP_A_PENDSET;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ctrl_r   <= 32'h0;
      reload_r <= 24'h0;
      vbase_r  <= 32'h0;
      mask_r   <= 3'h0;
      nmisel_r <= 9'h000;
      sel_r    <= 6'h00;
      en_r     <= '0;
      for (int i = 0; i < NIRQ; i++)
        prio_r[i] <= 3'h0;
      for (int r = 0; r < NRGN; r++)
      begin
        rgn_base_r[r] <= 32'h0;
        rgn_attr_r[r] <= 32'h0;
      end
    end
    else if (wr_q_r)
    begin
      unique case (wa_q_r)
        `CEP_A_CTRL:   ctrl_r   <= hwdata;
        `CEP_A_RELOAD: reload_r <= hwdata[23:0];
        `CEP_A_VBASE:  vbase_r  <= hwdata;
        `CEP_A_MASK:   mask_r   <= hwdata[2:0];
        `CEP_A_NMISEL: nmisel_r <= hwdata[8:0];
        `CEP_A_IRQSEL: sel_r    <= hwdata[5:0];
        `CEP_A_IRQCFG:
        begin
          en_r[sel_r]   <= hwdata[0];
          prio_r[sel_r] <= hwdata[`CEP_CFG_PRIO_LSB +: 3];
        end
        default:
          if (wa_q_r >= `CEP_A_RGN && wa_q_r < `CEP_A_RGN_END)
          begin
            if (wa_q_r[2])
              rgn_attr_r[wa_q_r[5:3]] <= hwdata;
            else
              rgn_base_r[wa_q_r[5:3]] <= hwdata;
          end
      endcase
    end

  // ----------------------------------------
  // Memory region guard
  // ----------------------------------------
  logic        allow_c;
  logic        block_c;
  logic        ro_c;
  logic        block_r;
  logic        mf_pend_r;
  logic [31:0] faddr_r;

  always_comb
  begin
    allow_c = 1'b0;
    ro_c    = 1'b0;
    // Higher-numbered region overrides on overlap
    for (int r = 0; r < NRGN; r++)
      if (rgn_hit(rgn_base_r[r], rgn_attr_r[r], mem_addr))
      begin
        ro_c    = rgn_attr_r[r][`CEP_ATTR_RO] && !rgn_attr_r[r][`CEP_ATTR_RW];
        allow_c = rgn_attr_r[r][`CEP_ATTR_RW] || (ro_c && !mem_write);
      end
  end

  assign block_c = ctrl_r[`CEP_CTRL_GUARD_EN] && mem_valid && !allow_c;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      block_r <= 1'b0;
      faddr_r <= 32'h0;
    end
    else
    begin
      block_r <= block_c;
      if (block_c)
        faddr_r <= mem_addr;
    end

  a_guard_block : assert property (mem_valid && ctrl_r[`CEP_CTRL_GUARD_EN]
    && !allow_c |=> block_r && faddr_r == $past(mem_addr)) else $error("access not blocked");
  a_guard_ro : assert property (mem_valid && mem_write && ro_c
    && ctrl_r[`CEP_CTRL_GUARD_EN] |=> block_r ##1 mf_pend_r) else $error("ro write passed");

  // ----------------------------------------
  // Tick timer
  // ----------------------------------------
  logic tick_exp;
  logic tick_pend_r;

  cep_tick_timer #(.DIV(TDIV), .W(24)) u_tick (
    .clk     (clk),
    .nrst    (nrst),
    .enable  (ctrl_r[`CEP_CTRL_TICK_EN]),
    .src_div (ctrl_r[`CEP_CTRL_TICK_DIV]),
    .reload  (reload_r),
    .value   (tick_val),
    .expire  (tick_exp)
  );

  // ----------------------------------------
  // Pending state and arbitration
  // ----------------------------------------
  logic [NIRQ-1:0] s1_r;
  logic [NIRQ-1:0] s2_r;
  logic [NIRQ-1:0] pend_r;
  logic            win_v;
  logic [3:0]      win_rank;
  logic [7:0]      win_num;
  logic            nmi_c;
  logic            cand;
  logic            any_c;
  logic            clr_c;
  logic [7:0]      tgt_num;
  logic [3:0]      tgt_rank;
  logic [7:0]      cur_num_r;
  logic [3:0]      cur_rank_r;
  logic [3:0]      cnt_r;
  cep_pkg::cep_state_t st_r;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= irq_line;
      s2_r <= s1_r;
    end

  assign nmi_c = nmisel_r[`CEP_NMI_EN] && pend_r[nmisel_r[5:0]];

  always_comb
  begin
    win_v    = 1'b0;
    win_rank = 4'hf;
    win_num  = 8'h00;
    cand     = 1'b0;
    any_c    = nmi_c || tick_pend_r || mf_pend_r;
    // Descending scan with <= leaves the lowest number on a tie
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      cand = pend_r[i] && en_r[i] && !(nmisel_r[`CEP_NMI_EN] && nmisel_r[5:0] == 6'(i));
      any_c = any_c || cand;
      if (cand && (mask_r == 3'h0 || prio_r[i] < mask_r)
          && (!win_v || {1'b1, prio_r[i]} <= win_rank))
      begin
        win_v    = 1'b1;
        win_rank = {1'b1, prio_r[i]};
        win_num  = `CEP_EXC_IRQ0 + 8'(i);
      end
    end
    if (tick_pend_r)
    begin
      win_v    = 1'b1;
      win_rank = `CEP_RANK_TICK;
      win_num  = `CEP_EXC_TICK;
    end
    if (mf_pend_r)
    begin
      win_v    = 1'b1;
      win_rank = `CEP_RANK_MF;
      win_num  = `CEP_EXC_MF;
    end
    if (nmi_c)
    begin
      win_v    = 1'b1;
      win_rank = `CEP_RANK_NMI;
      win_num  = `CEP_EXC_NMI;
    end
  end

  // More urgent arrival during save takes over the same entry
  assign tgt_num  = (win_v && win_rank < cur_rank_r) ? win_num : cur_num_r;
  assign tgt_rank = (win_v && win_rank < cur_rank_r) ? win_rank : cur_rank_r;
  assign clr_c    = st_r == cep_pkg::cep_st_save && cnt_r == `CEP_SAVE_CYC - 4'h1;

  // Hardware sets win over the clear at entry
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pend_r      <= '0;
      tick_pend_r <= 1'b0;
      mf_pend_r   <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NIRQ; i++)
        if (s2_r[i] || (pset_c && hwdata[5:0] == 6'(i)))
          pend_r[i] <= 1'b1;
        else if (clr_c && (tgt_num == `CEP_EXC_IRQ0 + 8'(i)
                 || (tgt_num == `CEP_EXC_NMI && nmisel_r[5:0] == 6'(i))))
          pend_r[i] <= 1'b0;
      if (tick_exp)
        tick_pend_r <= 1'b1;
      else if (clr_c && tgt_num == `CEP_EXC_TICK)
        tick_pend_r <= 1'b0;
      if (block_r)
        mf_pend_r <= 1'b1;
      else if (clr_c && tgt_num == `CEP_EXC_MF)
        mf_pend_r <= 1'b0;
    end

  a_tick_raise : assert property (tick_exp |=> tick_pend_r) else $error("tick lost");
  a_pend_set : assert property (pset_c |=> pend_r[$past(hwdata[5:0])])
    else $error("pend set lost");
  a_nmi_route : assert property (st_r == cep_pkg::cep_st_idle && nmi_c
    |=> cur_num_r == `CEP_EXC_NMI) else $error("nmi not routed");

  // ----------------------------------------
  // Entry and return sequencing
  // ----------------------------------------
  logic        req_r;
  logic [31:0] vec_r;
  logic        save_r;
  logic        restore_r;
  logic        wake_r;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      st_r       <= cep_pkg::cep_st_idle;
      cnt_r      <= 4'h0;
      cur_num_r  <= 8'h00;
      cur_rank_r <= 4'hf;
      req_r      <= 1'b0;
      vec_r      <= 32'h0;
      save_r     <= 1'b0;
      restore_r  <= 1'b0;
    end
    else
    begin
      save_r    <= 1'b0;
      restore_r <= 1'b0;
      unique case (st_r)
        cep_pkg::cep_st_idle:
          if (win_v)
          begin
            st_r       <= cep_pkg::cep_st_save;
            cnt_r      <= 4'h0;
            cur_num_r  <= win_num;
            cur_rank_r <= win_rank;
            save_r     <= 1'b1;
          end
        cep_pkg::cep_st_save:
        begin
          cur_num_r  <= tgt_num;
          cur_rank_r <= tgt_rank;
          cnt_r      <= cnt_r + 4'h1;
          if (clr_c)
          begin
            st_r  <= cep_pkg::cep_st_active;
            req_r <= 1'b1;
            vec_r <= vec_of(vbase_r, tgt_num);
          end
        end
        cep_pkg::cep_st_active:
          if (exc_return)
          begin
            st_r      <= cep_pkg::cep_st_restore;
            cnt_r     <= 4'h0;
            req_r     <= 1'b0;
            restore_r <= 1'b1;
          end
        cep_pkg::cep_st_restore:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `CEP_SAVE_CYC - 4'h1)
          begin
            st_r       <= cep_pkg::cep_st_idle;
            cur_rank_r <= 4'hf;
          end
        end
      endcase
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      wake_r <= 1'b0;
    else
      wake_r <= core_sleep && any_c;

  sequence s_enter;
    save_r ##1 !save_r [*7];
  endsequence

  a_ctx_save : assert property (st_r == cep_pkg::cep_st_idle && win_v
    |=> s_enter ##1 req_r) else $error("entry save sequence wrong");
  a_late_swap : assert property (st_r == cep_pkg::cep_st_save && win_v
    && win_rank < cur_rank_r |=> cur_num_r == $past(win_num) && !save_r
    && cnt_r == $past(cnt_r) + 4'h1) else $error("late arrival not taken");
  // Written apart from vec_of so that a fault in the helper shows up here
  a_vec_addr : assert property ($rose(req_r)
    |-> vec_r == {vbase_r[31:`CEP_VBASE_LSB], 7'h00} + (32'(cur_num_r) << 2))
    else $error("vector address wrong");
  a_mask_hold : assert property ($rose(req_r) && cur_num_r >= `CEP_EXC_IRQ0 && mask_r != 3'h0
    |-> cur_rank_r[2:0] < mask_r) else $error("masked request taken");
  a_wake : assert property (core_sleep && any_c |=> wake_r) else $error("no wake");
  a_restore : assert property (st_r == cep_pkg::cep_st_active && exc_return
    |=> restore_r ##8 st_r == cep_pkg::cep_st_idle) else $error("restore wrong");

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_c = 32'h0;
    unique case (haddr[11:0])
      `CEP_A_CTRL:   rd_c = ctrl_r;
      `CEP_A_RELOAD: rd_c = {8'h00, reload_r};
      `CEP_A_VALUE:  rd_c = {8'h00, tick_val};
      `CEP_A_VBASE:  rd_c = {vbase_r[31:`CEP_VBASE_LSB], 7'h00};
      `CEP_A_MASK:   rd_c = {29'h0, mask_r};
      `CEP_A_NMISEL: rd_c = {23'h0, nmisel_r};
      `CEP_A_IRQSEL: rd_c = {26'h0, sel_r};
      `CEP_A_IRQCFG: rd_c = {25'h0, prio_r[sel_r], 2'b00, pend_r[sel_r], en_r[sel_r]};
      `CEP_A_STATUS: rd_c = {21'h0, tick_pend_r, mf_pend_r, req_r, cur_num_r};
      `CEP_A_FADDR:  rd_c = faddr_r;
      default:
        if (haddr[11:0] >= `CEP_A_RGN && haddr[11:0] < `CEP_A_RGN_END)
          rd_c = haddr[2] ? rgn_attr_r[haddr[5:3]] : rgn_base_r[haddr[5:3]];
    endcase
  end

  assign hreadyout   = hready_r;
  assign hresp       = hresp_r;
  assign hrdata      = hrdata_r;
  assign exc_req     = req_r;
  assign exc_num     = cur_num_r;
  assign exc_vec     = vec_r;
  assign ctx_save    = save_r;
  assign ctx_restore = restore_r;
  assign mem_block   = block_r;
  assign wake        = wake_r;
endmodule

// >>> src/cep_defs.svh
// Register map, field positions and fixed codes of the exception block.
// Assumes word-aligned AHB-Lite accesses decoded on the low 12 address bits.
`ifndef CEP_DEFS_SVH
`define CEP_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CEP_A_CTRL     12'h000
`define CEP_A_RELOAD   12'h004
`define CEP_A_VALUE    12'h008
`define CEP_A_VBASE    12'h00c
`define CEP_A_MASK     12'h010
`define CEP_A_NMISEL   12'h014
`define CEP_A_IRQSEL   12'h018
`define CEP_A_IRQCFG   12'h01c
`define CEP_A_PENDSET  12'h020
`define CEP_A_STATUS   12'h024
`define CEP_A_FADDR    12'h028
`define CEP_A_RGN      12'h040
`define CEP_A_RGN_END  12'h080

// ----------------------------------------
// Fields
// ----------------------------------------
`define CEP_CTRL_TICK_EN  0
`define CEP_CTRL_TICK_DIV 1
`define CEP_CTRL_GUARD_EN 2
`define CEP_NMI_EN        8
`define CEP_VBASE_LSB     7
`define CEP_ATTR_EN       0
`define CEP_ATTR_RO       1
`define CEP_ATTR_RW       2
`define CEP_ATTR_SRD_LSB  8
`define CEP_ATTR_SIZE_LSB 16
`define CEP_SIZE_MIN      5'h05
`define CEP_CFG_PEND      1
`define CEP_CFG_PRIO_LSB  4

// ----------------------------------------
// Exception numbers, ranks, timing
// ----------------------------------------
`define CEP_EXC_NMI   8'h02
`define CEP_EXC_MF    8'h04
`define CEP_EXC_TICK  8'h0f
`define CEP_EXC_IRQ0  8'h10
`define CEP_RANK_NMI  4'h0
`define CEP_RANK_MF   4'h1
`define CEP_RANK_TICK 4'h2
`define CEP_SAVE_CYC  4'h8

`endif

// >>> src/cep_pkg.sv
// Types shared by the exception block.
// Assumes cep_defs.svh supplies all numeric constants except the state codes below.
package cep_pkg;
  typedef enum logic [3:0]
  {
    cep_st_idle    = 4'b0001,
    cep_st_save    = 4'b0010,
    cep_st_active  = 4'b0100,
    cep_st_restore = 4'b1000
  } cep_state_t;
endpackage

// >>> src/cep_tick_timer.sv
// System tick timer: down counter that reloads and pulses on expiry.
// Assumes reload and control come from same-clock register logic.
`timescale 1ns/10ps
module cep_tick_timer #(
  parameter int DIV = 8,
  parameter int W   = 24
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         enable,
  input  wire logic         src_div,
  input  wire logic [W-1:0] reload,
  output logic      [W-1:0] value,
  output logic              expire
);
  logic [7:0]   pre_r;
  logic [W-1:0] cnt_r;
  logic         exp_r;
  logic         step_c;

  // Divided source steps once every DIV system clocks
  assign step_c = enable && (!src_div || pre_r == 8'(DIV - 1));

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      pre_r <= 8'h00;
    else if (!enable || pre_r == 8'(DIV - 1))
      pre_r <= 8'h00;
    else
      pre_r <= pre_r + 8'h01;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      exp_r <= step_c && cnt_r == '0 && reload != '0;
      if (step_c)
        cnt_r <= (cnt_r == '0) ? reload : cnt_r - 1'b1;
    end

  assign value  = cnt_r;
  assign expire = exp_r;
endmodule

// >>> testbench/cep_core_model.sv
// Core stand-in: answers every exception with one return pulse.
// Assumes exc_req is a level on the same clock as the exception block.
`timescale 1ns/10ps
module cep_core_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       exc_req,
  input  wire logic [7:0] ret_wait,
  output logic            exc_return
);
  logic [7:0] cnt_r;

  // Return only while an exception stands, after ret_wait cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r      <= 8'h00;
      exc_return <= 1'b0;
    end
    else
    begin
      exc_return <= exc_req && !exc_return && cnt_r == ret_wait;
      cnt_r      <= (exc_req && !exc_return) ? cnt_r + 8'h01 : 8'h00;
    end
  end
endmodule

// >>> testbench/core_exception_and_protection_bench.sv
// Self-checking bench of the exception block with a core stand-in.
// Assumes one AHB-Lite master and zero-wait register answers.
`timescale 1ns/10ps
`include "cep_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module core_exception_and_protection_bench;
  localparam logic [31:0] VB = 32'h0000_0400;
  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, core_sleep, exc_return;
  logic        mem_valid, mem_write, exc_req, ctx_save, ctx_restore, mem_block, wake;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  exc_num, ret_wait;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, exc_vec, rdat, v1;
  logic [55:0] irq_line;
  int          n_errors, n_tests, cyc;

  cep_core_exc u_cep_core_exc (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_line(irq_line),
    .core_sleep(core_sleep), .exc_return(exc_return), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_write(mem_write), .exc_req(exc_req), .exc_num(exc_num),
    .exc_vec(exc_vec), .ctx_save(ctx_save), .ctx_restore(ctx_restore),
    .mem_block(mem_block), .wake(wake));

  cep_core_model u_cep_core_model (
    .clk(clk), .nrst(nrst), .exc_req(exc_req), .ret_wait(ret_wait),
    .exc_return(exc_return));

  // ----------------------------------------
  // Bus and core helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdat = hrdata;
  endtask

  task automatic cfg(input logic [5:0] n, input logic [2:0] p);
    bus(1'b1, `CEP_A_IRQSEL, {26'h0, n});
    bus(1'b1, `CEP_A_IRQCFG, {25'h0, p, 4'h1});
  endtask

  // One whole entry and return; a second save would mean a repeated entry
  task automatic take(input logic [7:0] num);
    int saves, gap, i;
    saves = 0;
    gap   = 0;
    for (i = 0; i < 300 && exc_req !== 1'b1; i++)
    begin
      @(posedge clk);
      saves += (ctx_save === 1'b1);
      gap   += (saves > 0);
    end
    `CHK(saves, 1)
    `CHK(gap, 9)
    `CHK(exc_num, num)
    `CHK(exc_vec, VB + {22'h0, num, 2'b00})
    for (i = 0; i < 300 && ctx_restore !== 1'b1; i++) @(posedge clk);
    `CHK({ctx_restore, exc_req}, 2'b10)
  endtask

  task automatic acc(input logic [31:0] a, input logic w, input logic blk);
    mem_valid <= 1'b1;
    mem_addr  <= a;
    mem_write <= w;
    @(posedge clk);
    mem_valid <= 1'b0;
    @(posedge clk);
    `CHK(mem_block, blk)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_tick;
    bus(1'b1, `CEP_A_VBASE, VB);
    bus(1'b0, `CEP_A_VBASE, 32'h0);
    `CHK(rdat, VB)
    bus(1'b0, 12'h030, 32'h0);
    `CHK(rdat, 32'h0)
    bus(1'b1, `CEP_A_RELOAD, 32'h3);
    bus(1'b1, `CEP_A_CTRL, 32'h1);
    take(`CEP_EXC_TICK);
    bus(1'b1, `CEP_A_RELOAD, 32'h1000);
    repeat (10) @(posedge clk);
    for (int m = 1; m <= 3; m += 2)
    begin
      bus(1'b1, `CEP_A_CTRL, m);
      bus(1'b0, `CEP_A_VALUE, 32'h0);
      v1 = rdat;
      repeat (6) @(posedge clk);
      bus(1'b0, `CEP_A_VALUE, 32'h0);
      `CHK(v1 - rdat, (m == 1) ? 32'h8 : 32'h1)
    end
    bus(1'b1, `CEP_A_CTRL, 32'h0);
    repeat (60) @(posedge clk);
  endtask

  task automatic t_guard;
    bus(1'b1, 12'h040, 32'h2000_0000);
    bus(1'b1, 12'h044, 32'h000c_0203);
    bus(1'b1, 12'h078, 32'h3000_0000);
    bus(1'b1, 12'h07c, 32'h000c_0005);
    bus(1'b1, `CEP_A_CTRL, 32'h4);
    acc(32'h2000_0010, 1'b0, 1'b0);
    acc(32'h2000_0010, 1'b1, 1'b1);
    take(`CEP_EXC_MF);
    acc(32'h2000_0210, 1'b0, 1'b1);
    acc(32'h3000_0010, 1'b1, 1'b0);
    acc(32'h4000_0000, 1'b0, 1'b1);
    bus(1'b0, `CEP_A_FADDR, 32'h0);
    `CHK(rdat, 32'h4000_0000)
    bus(1'b1, `CEP_A_CTRL, 32'h0);
    repeat (80) @(posedge clk);
  endtask

  // Mask 3 holds off priority 3 but lets priority 2 through
  task automatic t_irq;
    cfg(6'h05, 3'h3);
    cfg(6'h03, 3'h3);
    cfg(6'h09, 3'h2);
    bus(1'b1, `CEP_A_MASK, 32'h3);
    bus(1'b1, `CEP_A_PENDSET, 32'h5);
    bus(1'b1, `CEP_A_PENDSET, 32'h3);
    repeat (20) @(posedge clk);
    `CHK(exc_req, 1'b0)
    bus(1'b1, `CEP_A_PENDSET, 32'h9);
    take(8'h19);
    bus(1'b1, `CEP_A_MASK, 32'h0);
    take(8'h13);
    take(8'h15);
  endtask

  task automatic t_wake;
    int i;
    core_sleep   <= 1'b1;
    irq_line[9]  <= 1'b1;
    for (i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
    `CHK(wake, 1'b1)
    irq_line[9]  <= 1'b0;
    core_sleep   <= 1'b0;
    repeat (80) @(posedge clk);
  endtask

  // NMI source arrives during the save of a peripheral entry
  task automatic t_nmi;
    ret_wait <= 8'd40;
    bus(1'b1, `CEP_A_NMISEL, 32'h0000_0107);
    bus(1'b1, `CEP_A_PENDSET, 32'h9);
    irq_line[7] <= 1'b1;
    take(`CEP_EXC_NMI);
    irq_line[7] <= 1'b0;
    ret_wait    <= 8'd2;
    repeat (150) @(posedge clk);
  endtask

  task give_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, sequence, timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {nrst, hsel, hwrite, core_sleep, mem_valid, mem_write} = 6'h00;
    {haddr, hwdata, mem_addr, irq_line} = '0;
    htrans   = 2'b00;
    hsize    = 3'b010;
    ret_wait = 8'd2;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK({hreadyout, hresp, exc_req, ctx_save, ctx_restore, mem_block, wake}, 7'h40)
    t_tick();
    t_guard();
    t_irq();
    t_wake();
    t_nmi();
    give_verdict();
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
endmodule
